// >>> design/imu_framer_pkg.sv
package imu_framer_pkg;

    // ------------------------------------------------------------
    // Field indices and lengths
    // ------------------------------------------------------------
    localparam int         FIELD_COUNT  = 11;
    localparam logic [3:0] F_STATUS     = 4'h0;
    localparam logic [3:0] F_RAW_FIELD  = 4'h1;
    localparam logic [3:0] F_RAW_FORCE  = 4'h2;
    localparam logic [3:0] F_RAW_TURN   = 4'h3;
    localparam logic [3:0] F_TEMP       = 4'h4;
    localparam logic [3:0] F_PRES       = 4'h5;
    localparam logic [3:0] F_ANGLE      = 4'h6;
    localparam logic [3:0] F_VELOCITY   = 4'h7;
    localparam logic [3:0] F_COMP_FIELD = 4'h8;
    localparam logic [3:0] F_COMP_FORCE = 4'h9;
    localparam logic [3:0] F_COMP_TURN  = 4'hA;
    localparam logic [3:0] F_DONE       = 4'hB;
    // Byte length of each field, index 10 first
    localparam logic [10:0][4:0] FIELD_LEN = {
        5'h0C, 5'h0C, 5'h0C, 5'h0C, 5'h10, 5'h04,
        5'h04, 5'h0C, 5'h0C, 5'h0C, 5'h02};

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0]  A_GROUP_SEL    = 8'h00;
    localparam logic [7:0]  A_FRAME        = 8'h04;
    localparam logic [7:0]  A_COMMAND      = 8'h08;
    localparam logic [7:0]  A_STATUS       = 8'h0C;
    localparam logic [7:0]  A_POLL_DTIME   = 8'h10;
    localparam logic [7:0]  A_POLL_DTH_X   = 8'h14;
    localparam logic [7:0]  A_POLL_DTH_Y   = 8'h18;
    localparam logic [7:0]  A_POLL_DTH_Z   = 8'h1C;
    localparam logic [7:0]  A_POLL_DV_X    = 8'h20;
    localparam logic [7:0]  A_POLL_DV_Y    = 8'h24;
    localparam logic [7:0]  A_POLL_DV_Z    = 8'h28;
    localparam logic [15:0] GROUP_SEL_MASK = 16'h07FF;
    localparam int          CMD_SEND_BIT   = 0;
    localparam int          CMD_POLL_BIT   = 1;
    localparam int          ST_BUSY_BIT    = 0;
    localparam int          ST_CNT_LSB     = 8;

    // ------------------------------------------------------------
    // Fixed-point scaling of the accumulators
    // ------------------------------------------------------------
    localparam int          ANG_FRAC      = 16;
    localparam int          VEL_FRAC      = 16;
    localparam int          DT_FRAC       = 24;
    localparam int          IMU_RATE_HZ   = 800;
    localparam logic [31:0] DT_PER_SAMPLE =
        32'(((2 ** DT_FRAC) + (IMU_RATE_HZ / 2)) / IMU_RATE_HZ);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [31:0] f32_t;
    typedef f32_t [2:0]  vec3_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } framer_state_e;

    typedef struct packed {
        vec3_t raw_field_strength;
        vec3_t raw_specific_force;
        vec3_t raw_turn_rate;
        f32_t  temperature;
        f32_t  pressure;
        vec3_t comp_field_strength;
        vec3_t comp_specific_force;
        vec3_t turn_rate_vector;
    } imu_fields_s;

    // Per-sample increments, already coning/sculling corrected
    typedef struct packed {
        logic [2:0][31:0] dtheta;
        logic [2:0][31:0] dvel;
        logic             frame;
    } imu_sample_s;

    typedef struct packed {
        f32_t  dtime;
        vec3_t dtheta;
        vec3_t dvel;
    } incr_s;

    typedef struct packed {
        logic [31:0] acc;
    } acc_state_s;

    typedef struct packed {
        framer_state_e state;
        logic [15:0]   sel;
        logic [15:0]   pkt_sel;
        logic          frame;
        logic [3:0]    field;
        logic [4:0]    byte_idx;
        logic          valid;
        logic [7:0]    data;
        logic          last;
        imu_fields_s   snap;
        incr_s         held;
        incr_s         polled;
        logic [7:0]    sample_cnt;
        logic [31:0]   prdata;
    } framer_state_s;

    localparam framer_state_s FRAMER_RST = '0;
    localparam acc_state_s    ACC_RST    = '0;

endpackage

// >>> design/imu_output_group_framer.sv
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps

module imu_output_group_framer
    import imu_framer_pkg::*;
(
    input  wire logic                        mclk,
    input  wire logic                        reset,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        send_req,
    input  wire imu_framer_pkg::imu_fields_s imu_fields,
    input  wire logic                        sample_valid,
    input  wire imu_framer_pkg::imu_sample_s sample,
    output logic                             reference_frame_select,
    output logic                             pkt_valid,
    input  wire logic                        pkt_ready,
    output logic      [7:0]                  pkt_data,
    output logic                             pkt_last,
    output logic                             busy
);
    import imu_framer_pkg::*;

    framer_state_s    s_r;
    framer_state_s    s_nxt;
    logic [6:0][31:0] acc_val;
    logic [6:0][31:0] acc_inc;
    f32_t [6:0]       acc_flt;
    incr_s            cur_incr;
    incr_s            hold_v;
    logic             clr;
    logic             sample_ok;
    logic             wr_acc;
    logic             rd_setup;
    logic             mapped;
    logic             send_cmd;
    logic             poll_cmd;
    logic [3:0]       nf;
    logic [4:0]       nb;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] next_field(input logic [15:0] sel,
                                              input logic [4:0]  from);
        logic [3:0] r;
        r = F_DONE;
        for (int i = FIELD_COUNT - 1; i >= 0; i--) begin
            if (sel[i] && (5'(i) >= from)) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] byte_at(input imu_fields_s snap,
                                           input incr_s       held,
                                           input logic [3:0]  f,
                                           input logic [4:0]  b);
        logic [31:0] w;
        logic [1:0]  k;
        w = 32'h0;
        k = b[3:2];
        case (f)
            F_STATUS:     w = 32'h0;
            F_RAW_FIELD:  w = snap.raw_field_strength[k];
            F_RAW_FORCE:  w = snap.raw_specific_force[k];
            F_RAW_TURN:   w = snap.raw_turn_rate[k];
            F_TEMP:       w = snap.temperature;
            F_PRES:       w = snap.pressure;
            F_ANGLE: begin
                w = (b[4:2] == 3'h0) ? held.dtime
                                     : held.dtheta[2'(b[4:2] - 3'h1)];
            end
            F_VELOCITY:   w = held.dvel[k];
            F_COMP_FIELD: w = snap.comp_field_strength[k];
            F_COMP_FORCE: w = snap.comp_specific_force[k];
            F_COMP_TURN:  w = snap.turn_rate_vector[k];
            default:      w = 32'h0;
        endcase
        return w[{b[1:0], 3'b000} +: 8];
    endfunction

    function automatic logic is_last(input logic [15:0] sel,
                                     input logic [3:0]  f,
                                     input logic [4:0]  b);
        return (b == FIELD_LEN[f] - 5'h01) &&
               (next_field(sel, 5'(f) + 5'h01) == F_DONE);
    endfunction

    // ------------------------------------------------------------
    // Increment accumulators
    // ------------------------------------------------------------
    // Samples tagged with another frame are dropped; a sample of the old
    // frame in the cycle of a frame switch still starts the new sum
    assign sample_ok = sample_valid && (sample.frame == s_r.frame);

    // Index 0 is the interval, 1..3 angle, 4..6 velocity
    always_comb begin
        acc_inc[0] = DT_PER_SAMPLE;
        for (int i = 0; i < 3; i++) begin
            acc_inc[1 + i] = sample.dtheta[i];
            acc_inc[4 + i] = sample.dvel[i];
        end
    end

    for (genvar g = 0; g < 7; g++) begin : g_acc
        incr_accum u_acc (
            .mclk  (mclk),
            .reset (reset),
            .clr   (clr),
            .add   (sample_ok),
            .inc   (acc_inc[g]),
            .acc   (acc_val[g])
        );
        int2float #(
            .FRAC   (g == 0 ? DT_FRAC : (g < 4 ? ANG_FRAC : VEL_FRAC)),
            .SIGNED (g != 0)
        ) u_cvt (
            .value (acc_val[g]),
            .flt   (acc_flt[g])
        );
    end

    assign cur_incr = '{dtime:  acc_flt[0],
                        dtheta: {acc_flt[3], acc_flt[2], acc_flt[1]},
                        dvel:   {acc_flt[6], acc_flt[5], acc_flt[4]}};

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign wr_acc   = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= A_POLL_DV_Z);
    assign send_cmd = wr_acc && (paddr == A_COMMAND) && pwdata[CMD_SEND_BIT];
    assign poll_cmd = wr_acc && (paddr == A_COMMAND) && pwdata[CMD_POLL_BIT];

    // ------------------------------------------------------------
    // Next state: registers, accumulator clears, byte sequencer
    // ------------------------------------------------------------
    always_comb begin
        s_nxt  = s_r;
        clr    = 1'b0;
        nf     = s_r.field;
        nb     = s_r.byte_idx;
        hold_v = s_r.held;
        // Register writes; upper group bits are not stored
        if (wr_acc && (paddr == A_GROUP_SEL)) begin
            s_nxt.sel = pwdata[15:0] & GROUP_SEL_MASK;
        end
        if (wr_acc && (paddr == A_FRAME)) begin
            s_nxt.frame = pwdata[0];
            if (pwdata[0] != s_r.frame) begin
                clr = 1'b1;
            end
        end
        // A poll hands both records to software and restarts them
        if (poll_cmd) begin
            s_nxt.polled = cur_incr;
            clr          = 1'b1;
        end
        // Read data is captured in the setup phase
        if (rd_setup) begin
            case (paddr)
                A_GROUP_SEL:  s_nxt.prdata = {16'h0, s_r.sel};
                A_FRAME:      s_nxt.prdata = {31'h0, s_r.frame};
                A_STATUS: begin
                    s_nxt.prdata = '0;
                    s_nxt.prdata[ST_BUSY_BIT] = (s_r.state == ST_SEND);
                    s_nxt.prdata[ST_CNT_LSB +: 8] = s_r.sample_cnt;
                end
                A_POLL_DTIME: s_nxt.prdata = s_r.polled.dtime;
                A_POLL_DTH_X: s_nxt.prdata = s_r.polled.dtheta[0];
                A_POLL_DTH_Y: s_nxt.prdata = s_r.polled.dtheta[1];
                A_POLL_DTH_Z: s_nxt.prdata = s_r.polled.dtheta[2];
                A_POLL_DV_X:  s_nxt.prdata = s_r.polled.dvel[0];
                A_POLL_DV_Y:  s_nxt.prdata = s_r.polled.dvel[1];
                A_POLL_DV_Z:  s_nxt.prdata = s_r.polled.dvel[2];
                default:      s_nxt.prdata = 32'h0;
            endcase
        end
        // Sequencer; a request while sending is ignored
        case (s_r.state)
            ST_IDLE: begin
                if (send_req || send_cmd) begin
                    nf = next_field(s_r.sel, 5'h00);
                    nb = 5'h00;
                    s_nxt.snap    = imu_fields;
                    s_nxt.pkt_sel = s_r.sel;
                    if (s_r.sel[F_ANGLE] || s_r.sel[F_VELOCITY]) begin
                        hold_v = cur_incr;
                        clr    = 1'b1;
                    end
                    s_nxt.held = hold_v;
                    if (nf != F_DONE) begin
                        s_nxt.state    = ST_SEND;
                        s_nxt.field    = nf;
                        s_nxt.byte_idx = nb;
                        s_nxt.valid    = 1'b1;
                        s_nxt.data     = byte_at(imu_fields, hold_v, nf, nb);
                        s_nxt.last     = is_last(s_r.sel, nf, nb);
                    end
                end
            end
            ST_SEND: begin
                if (pkt_ready) begin
                    if (s_r.last) begin
                        s_nxt.state = ST_IDLE;
                        s_nxt.valid = 1'b0;
                        s_nxt.last  = 1'b0;
                    end else begin
                        if (s_r.byte_idx == FIELD_LEN[s_r.field] - 5'h01) begin
                            nf = next_field(s_r.pkt_sel,
                                            5'(s_r.field) + 5'h01);
                            nb = 5'h00;
                        end else begin
                            nb = s_r.byte_idx + 5'h01;
                        end
                        s_nxt.field    = nf;
                        s_nxt.byte_idx = nb;
                        s_nxt.data     = byte_at(s_r.snap, s_r.held, nf, nb);
                        s_nxt.last     = is_last(s_r.pkt_sel, nf, nb);
                    end
                end
            end
            default: begin
                s_nxt.state = ST_IDLE;
                s_nxt.valid = 1'b0;
            end
        endcase
        // Samples since the last clear, saturating
        if (clr) begin
            s_nxt.sample_cnt = sample_ok ? 8'h01 : 8'h00;
        end else if (sample_ok && (s_r.sample_cnt != 8'hFF)) begin
            s_nxt.sample_cnt = s_r.sample_cnt + 8'h01;
        end
    end

    // State register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_r <= FRAMER_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero wait state slave: read data was caught in setup
    assign pready                 = 1'b1;
    assign pslverr                = psel && penable && !mapped;
    assign prdata                 = s_r.prdata;
    assign reference_frame_select = s_r.frame;
    assign pkt_valid              = s_r.valid;
    assign pkt_data               = s_r.data;
    assign pkt_last               = s_r.last;
    assign busy                   = (s_r.state == ST_SEND);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_field_enabled;
        @(posedge mclk) disable iff (reset)
        pkt_valid |-> s_r.pkt_sel[s_r.field] && (s_r.field < F_DONE);
    endproperty
    a_field_enabled: assert property (p_field_enabled)
        else $error("byte sent from a field that is not enabled");

    property p_status_zero;
        @(posedge mclk) disable iff (reset)
        pkt_valid && (s_r.field == F_STATUS)
            |-> (pkt_data == 8'h00) && (s_r.byte_idx < 5'h02);
    endproperty
    a_status_zero: assert property (p_status_zero)
        else $error("status field not two zero bytes");

    property p_field_len;
        @(posedge mclk) disable iff (reset)
        pkt_valid && pkt_ready && !pkt_last
            && (s_r.field == F_RAW_FIELD) && (s_r.byte_idx == 5'h0B)
            |=> pkt_valid && (s_r.field > F_RAW_FIELD)
                && (s_r.byte_idx == 5'h00);
    endproperty
    a_field_len: assert property (p_field_len)
        else $error("vector field not twelve bytes");

    property p_temp_byte;
        @(posedge mclk) disable iff (reset)
        pkt_valid && (s_r.field == F_TEMP) && (s_r.byte_idx == 5'h03)
            |-> pkt_data == s_r.snap.temperature[31:24];
    endproperty
    a_temp_byte: assert property (p_temp_byte)
        else $error("temperature top byte wrong");

    property p_pres_byte;
        @(posedge mclk) disable iff (reset)
        pkt_valid && (s_r.field == F_PRES) && (s_r.byte_idx == 5'h00)
            |-> pkt_data == s_r.snap.pressure[7:0];
    endproperty
    a_pres_byte: assert property (p_pres_byte)
        else $error("pressure low byte wrong");

    property p_angle_len;
        @(posedge mclk) disable iff (reset)
        pkt_valid && pkt_ready && (s_r.field == F_ANGLE)
            && (s_r.byte_idx == 5'h0F) && !pkt_last
            |=> s_r.field != F_ANGLE;
    endproperty
    a_angle_len: assert property (p_angle_len)
        else $error("angle record not sixteen bytes");

    property p_clear_on_send;
        @(posedge mclk) disable iff (reset)
        clr && !sample_ok |=> (acc_val == '0) && (s_r.sample_cnt == 8'h00);
    endproperty
    a_clear_on_send: assert property (p_clear_on_send)
        else $error("accumulators not cleared");

    property p_integrate;
        @(posedge mclk) disable iff (reset)
        sample_ok && !clr
            |=> acc_val[0] == $past(acc_val[0]) + DT_PER_SAMPLE;
    endproperty
    a_integrate: assert property (p_integrate)
        else $error("interval not advanced on sample");

    property p_vel_byte;
        @(posedge mclk) disable iff (reset)
        pkt_valid && (s_r.field == F_VELOCITY) && (s_r.byte_idx == 5'h08)
            |-> pkt_data == s_r.held.dvel[2][7:0];
    endproperty
    a_vel_byte: assert property (p_vel_byte)
        else $error("velocity Z low byte wrong");

    property p_frame_gate;
        @(posedge mclk) disable iff (reset)
        sample_valid && (sample.frame != s_r.frame) && !clr
            |=> acc_val[1] == $past(acc_val[1]);
    endproperty
    a_frame_gate: assert property (p_frame_gate)
        else $error("sample of foreign frame accumulated");

    property p_ascending;
        @(posedge mclk) disable iff (reset)
        pkt_valid && pkt_ready && !pkt_last
            |=> pkt_valid && (s_r.field >= $past(s_r.field));
    endproperty
    a_ascending: assert property (p_ascending)
        else $error("fields out of ascending order");
endmodule

// >>> design/incr_accum.sv
`timescale 1ns/1ps

// One increment accumulator; a clear in the same cycle as a sample
// restarts from that sample so no sample is dropped
module incr_accum
    import imu_framer_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        clr,
    input  wire logic        add,
    input  wire logic [31:0] inc,
    output logic      [31:0] acc
);
    acc_state_s s_r;
    acc_state_s s_nxt;

    // --------------------------------------------------------
    // Next value
    // --------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (clr) begin
            s_nxt.acc = add ? inc : 32'h0;
        end else if (add) begin
            s_nxt.acc = s_r.acc + inc;
        end
    end

    // State register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_r <= ACC_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign acc = s_r.acc;
endmodule

// >>> design/int2float.sv
`timescale 1ns/1ps

// Fixed-point to single-precision conversion, truncating the mantissa
module int2float #(
    parameter int FRAC   = 16,
    parameter bit SIGNED = 1'b1
) (
    input  wire logic [31:0] value,
    output logic      [31:0] flt
);
    logic [31:0] mag;
    logic [31:0] norm;
    logic [5:0]  msb;
    logic [7:0]  expo;
    logic        neg;

    // --------------------------------------------------------
    // Leading one search, normalise, build the word
    // --------------------------------------------------------
    always_comb begin
        neg = SIGNED && value[31];
        mag = neg ? 32'(-value) : value;
        msb = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if (mag[i]) begin
                msb = 6'(i);
            end
        end
        norm = mag << (6'h1F - msb);
        expo = 8'(127 + int'(msb) - FRAC);
        flt  = (mag == 32'h0) ? 32'h0 : {neg, expo, norm[30:8]};
    end
endmodule

// >>> dv/pkt_sink.sv
`timescale 1ns/1ps

// ----------------------------------------
// Host end of the packet byte stream
// ----------------------------------------
// Stalls one cycle in four when slow, so held bytes are exercised
module pkt_sink (
    input  wire logic       mclk,
    input  wire logic       slow,
    input  wire logic       pkt_valid,
    input  wire logic [7:0] pkt_data,
    input  wire logic       pkt_last,
    output logic            pkt_ready
);
    logic [7:0] rx_q[$];
    int         n_last = 0;
    logic [1:0] ph     = 2'h0;

    // A byte is taken only at an edge with valid and ready high
    always @(posedge mclk) begin
        ph <= ph + 2'h1;
        if (pkt_valid && pkt_ready) begin
            rx_q.push_back(pkt_data);
            if (pkt_last) n_last++;
        end
    end
    assign pkt_ready = !slow || (ph != 2'h0);
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps

module testbench;
    import imu_framer_pkg::*;
    typedef struct {logic [15:0] sel; int len; int idx; logic [7:0] b;} row_s;
    logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, send_req = 1'b0, sample_valid = 1'b0;
    logic slow = 1'b0, pready, pslverr, pkt_valid, pkt_ready, pkt_last;
    logic busy, frm, err;
    logic [7:0] paddr = 8'h00, pkt_data;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    imu_fields_s imu_fields;
    imu_sample_s sample;
    int n_mismatch = 0, checks = 0;
    row_s rows[10] = '{
        '{16'h0001, 2, 1, 8'h00}, '{16'h0002, 12, 0, 8'h11},
        '{16'h0010, 4, 2, 8'hA3}, '{16'h0020, 4, 3, 8'hB4},
        '{16'h0040, 16, 4, 8'h00}, '{16'h0080, 12, 11, 8'h00},
        '{16'h0400, 12, 8, 8'hC1}, '{16'h0031, 10, 6, 8'hB1},
        '{16'h07FF, 110, 109, 8'hC4}, '{16'h030C, 48, 47, 8'h00}};

    always #2.5 mclk = ~mclk;

    imu_output_group_framer imu_output_group_framer_i (.mclk(mclk),
        .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .send_req(send_req), .imu_fields(imu_fields),
        .sample_valid(sample_valid), .sample(sample),
        .reference_frame_select(frm), .pkt_valid(pkt_valid),
        .pkt_ready(pkt_ready), .pkt_data(pkt_data), .pkt_last(pkt_last),
        .busy(busy));
    pkt_sink pkt_sink_i (.mclk(mclk), .slow(slow), .pkt_valid(pkt_valid),
        .pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_ready(pkt_ready));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; called just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never re-drives psel in this step
        @(posedge mclk);
    endtask

    task automatic send(input logic [15:0] s);
        int k;
        apb(1'b1, A_GROUP_SEL, {16'h0, s});
        pkt_sink_i.rx_q.delete();
        k = pkt_sink_i.n_last;
        send_req <= 1'b1;
        @(posedge mclk);
        send_req <= 1'b0;
        for (int i = 0; i < 400 && pkt_sink_i.n_last == k; i++)
            @(posedge mclk);
    endtask

    // One IMU sample tagged with the given frame
    task automatic smp(input logic fr);
        sample.frame <= fr;
        sample_valid <= 1'b1;
        @(posedge mclk);
        sample_valid <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #200us;
        n_mismatch++;
        end_sim();
    end

    initial begin
        imu_fields = '0;
        imu_fields.raw_field_strength[0] = 32'h44332211;
        imu_fields.temperature = 32'hA4A3A2A1;
        imu_fields.pressure = 32'hB4B3B2B1;
        imu_fields.turn_rate_vector[2] = 32'hC4C3C2C1;
        sample = '{dtheta: {64'h0, 32'h00010000}, dvel: '0, frame: 1'b0};
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk({31'h0, busy}, 32'h0);
        apb(1'b0, A_GROUP_SEL, 32'h0);
        chk(rd, 32'h0);
        // Table of selections: length and one chosen byte
        foreach (rows[i]) begin
            slow <= i[0];
            send(rows[i].sel);
            chk(32'(pkt_sink_i.rx_q.size()), 32'(rows[i].len));
            chk({24'h0, pkt_sink_i.rx_q[rows[i].idx]}, {24'h0, rows[i].b});
            $display("test %0d done", i);
        end
        // Other-frame sample is ignored; two of 1.0 deg sum to 2.0
        smp(1'b0);
        smp(1'b1);
        smp(1'b0);
        apb(1'b1, A_COMMAND, 32'h2);
        apb(1'b0, A_POLL_DTH_X, 32'h0);
        chk(rd, 32'h40000000);
        apb(1'b1, A_COMMAND, 32'h2);
        apb(1'b0, A_POLL_DTH_X, 32'h0);
        chk(rd, 32'h0);
        $display("poll test done");
        // Sent angle record carries 1.0 deg, then accumulators are empty
        smp(1'b0);
        send(16'h0040);
        chk({24'h0, pkt_sink_i.rx_q[7]}, 32'h3F);
        apb(1'b1, A_COMMAND, 32'h2);
        apb(1'b0, A_POLL_DTH_X, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h2C, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("send clear test done");
        // Frame switch gates by tag (accumulators already empty); reset drops the frame
        apb(1'b1, A_FRAME, 32'h1);
        chk({31'h0, frm}, 32'h1);
        smp(1'b1);
        smp(1'b0);
        apb(1'b1, A_COMMAND, 32'h2);
        apb(1'b0, A_POLL_DTH_X, 32'h0);
        chk(rd, 32'h3F800000);
        reset <= 1'b1;
        @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk({31'h0, frm}, 32'h0);
        apb(1'b0, A_GROUP_SEL, 32'h0);
        chk(rd, 32'h0);
        $display("frame and reset test done");
        end_sim();
    end
endmodule
